//--- rtl/dmr_router.sv
// Address router of the cluster's request traffic onto two AXI master ports
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Neither master port ever issues a locked write, so the upper write-lock bit stays low.
// - Each master port ID is one bit wider than the coherency slave port ID, five bits by default.
// - The user sideband names the initiator as processor 0, processor 1 or the coherency port.
// - Both master ports may carry optional protection, here a parity bit over the control fields.
// - Filtering is active when the enable pin is high or the control register enable bit is set.
// - With filtering active, accesses inside the window go to the second port, all others to the first.
// - Window start and end load from the 12-bit straps on leaving reset and are writable later.
// - The window is 1MB granular and holds end minus start plus one megabytes, bounds inclusive.
// - Under filtering the port choice depends on the address alone, not on type or attributes.
// - Without filtering either port may be used as long as AXI ordering is preserved.
// - Without filtering locked and exclusive accesses always use the first port.
// - Distinct ID values separate traffic streams in flight together on a port.
module dmr_router #(
    parameter bit PAR_EN = 1'b0
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         reset_n,
    // Wishbone register slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [dmr_pkg::WB_AW-1:0]    wb_adr_i,
    input  wire logic [dmr_pkg::WB_DW-1:0]    wb_dat_i,
    input  wire logic [3:0]                   wb_sel_i,
    output logic      [dmr_pkg::WB_DW-1:0]    wb_dat_o,
    output logic                              wb_ack_o,
    output logic                              wb_err_o,
    // Filter pin and straps
    input  wire logic                         filter_enable_pin,
    input  wire logic [dmr_pkg::WIN_W-1:0]    filter_window_start_strap,
    input  wire logic [dmr_pkg::WIN_W-1:0]    filter_window_end_strap,
    // Upstream request channels
    input  wire logic                         up_aw_valid,
    input  wire dmr_pkg::dmr_req_t            up_aw,
    output logic                              up_aw_ready,
    input  wire logic                         up_ar_valid,
    input  wire dmr_pkg::dmr_req_t            up_ar,
    output logic                              up_ar_ready,
    // First master port
    output logic                              m0_aw_valid,
    output dmr_pkg::dmr_out_t                 m0_aw,
    input  wire logic                         m0_aw_ready,
    output logic                              m0_ar_valid,
    output dmr_pkg::dmr_out_t                 m0_ar,
    input  wire logic                         m0_ar_ready,
    output logic      [dmr_pkg::LOCK_W-1:0]   first_port_write_lock,
    // Second master port
    output logic                              m1_aw_valid,
    output dmr_pkg::dmr_out_t                 m1_aw,
    input  wire logic                         m1_aw_ready,
    output logic                              m1_ar_valid,
    output dmr_pkg::dmr_out_t                 m1_ar,
    input  wire logic                         m1_ar_ready,
    output logic      [dmr_pkg::LOCK_W-1:0]   second_port_write_lock
);

    // ******************************************************************
    // Functions
    // ******************************************************************
    function automatic logic route_port(
        input dmr_pkg::dmr_req_t           r,
        input logic                        on,
        input logic [dmr_pkg::WIN_W-1:0]   lo,
        input logic [dmr_pkg::WIN_W-1:0]   hi
    );
        logic [dmr_pkg::WIN_W-1:0] mb;
        mb = r.addr[dmr_pkg::WIN_MSB:dmr_pkg::WIN_LSB];
        // Only the address decides while filtering; type and lock are ignored
        if (on)
            route_port = (mb >= lo) && (mb <= hi);
        else if (r.lock != '0)
            route_port = dmr_pkg::PORT0;
        else
            // Fixed per initiator, so one initiator's unlocked requests never span both ports
            route_port = (r.src == dmr_pkg::SRC_CPU1);
    endfunction : route_port

    function automatic dmr_pkg::dmr_out_t shape(
        input dmr_pkg::dmr_req_t r,
        input logic              is_write
    );
        dmr_pkg::dmr_out_t o;
        o.addr = r.addr;
        o.id   = {r.src == dmr_pkg::SRC_CSP, r.id};
        o.len  = r.len;
        o.lock = r.lock;
        if (is_write)
            o.lock[dmr_pkg::LOCK_LOCKED_BIT] = 1'b0;
        o.user = r.src;
        o.par  = PAR_EN ? ^{o.addr, o.id, o.len, o.lock, o.user} : 1'b0;
        shape = o;
    endfunction : shape

    function automatic logic [dmr_pkg::WIN_W-1:0] merge_win(
        input logic [dmr_pkg::WIN_W-1:0]  old,
        input logic [dmr_pkg::WB_DW-1:0]  d,
        input logic [3:0]                 sel
    );
        merge_win = old;
        if (sel[0])
            merge_win[7:0] = d[7:0];
        if (sel[1])
            merge_win[11:8] = d[11:8];
    endfunction : merge_win

    // ******************************************************************
    // Pin and strap synchronisers
    // ******************************************************************
    logic [2:0]                 pin_sync_r;
    logic                       pin_level_r;
    logic [dmr_pkg::WIN_W-1:0]  st_s1_r, st_s2_r, st_s3_r;
    logic [dmr_pkg::WIN_W-1:0]  en_s1_r, en_s2_r, en_s3_r;
    logic                       loaded_r;
    logic [2:0]                 fill_r;
    wire                        pin_stable  = pin_sync_r[1] == pin_sync_r[2];
    wire                        strap_ok    = (st_s2_r == st_s3_r) && (en_s2_r == en_s3_r);
    // Stages start as equal reset zeros; only agreement after all have filled counts
    wire                        strap_load  = ~loaded_r & fill_r[2] & strap_ok;

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pin_sync_r  <= '0;
            fill_r      <= '0;
            pin_level_r <= 1'b0;
            st_s1_r     <= '0;
            st_s2_r     <= '0;
            st_s3_r     <= '0;
            en_s1_r     <= '0;
            en_s2_r     <= '0;
            en_s3_r     <= '0;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[1:0], filter_enable_pin};
            fill_r     <= {fill_r[1:0], 1'b1};
            if (pin_stable)
                pin_level_r <= pin_sync_r[2];
            st_s1_r <= filter_window_start_strap;
            st_s2_r <= st_s1_r;
            st_s3_r <= st_s2_r;
            en_s1_r <= filter_window_end_strap;
            en_s2_r <= en_s1_r;
            en_s3_r <= en_s2_r;
        end
    end

    // ******************************************************************
    // Register file
    // ******************************************************************
    logic                       ctrl_en_r;
    logic [dmr_pkg::WIN_W-1:0]  start_r;
    logic [dmr_pkg::WIN_W-1:0]  end_r;
    logic [dmr_pkg::WB_DW-1:0]  rd_data;
    wire                        filt_on  = pin_level_r | ctrl_en_r;
    wire                        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire                        sel_ctrl = wb_adr_i == dmr_pkg::REG_CTRL;
    wire                        sel_st   = wb_adr_i == dmr_pkg::REG_START;
    wire                        sel_end  = wb_adr_i == dmr_pkg::REG_END;
    wire                        sel_stat = wb_adr_i == dmr_pkg::REG_STATUS;
    wire                        mapped   = sel_ctrl | sel_st | sel_end | sel_stat;
    wire                        wr       = wb_req & wb_we_i & mapped;

    always_comb
    begin
        rd_data = '0;
        if (sel_ctrl)
            rd_data[dmr_pkg::CTRL_FILT_BIT] = ctrl_en_r;
        if (sel_st)
            rd_data[dmr_pkg::WIN_W-1:0] = start_r;
        if (sel_end)
            rd_data[dmr_pkg::WIN_W-1:0] = end_r;
        if (sel_stat)
        begin
            rd_data[dmr_pkg::STAT_FILT_BIT] = filt_on;
            rd_data[dmr_pkg::STAT_PIN_BIT]  = pin_level_r;
            rd_data[dmr_pkg::STAT_LOAD_BIT] = loaded_r;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            ctrl_en_r <= 1'b0;
            start_r   <= dmr_pkg::WIN_RST;
            end_r     <= dmr_pkg::WIN_RST;
            loaded_r  <= 1'b0;
            wb_ack_o  <= 1'b0;
            wb_err_o  <= 1'b0;
            wb_dat_o  <= '0;
        end
        else
        begin
            wb_ack_o <= wb_req & mapped;
            wb_err_o <= wb_req & ~mapped;
            if (wb_req)
                wb_dat_o <= rd_data;
            if (wr & sel_ctrl & wb_sel_i[0])
                ctrl_en_r <= wb_dat_i[dmr_pkg::CTRL_FILT_BIT];
            // Strap capture outranks a software write in the same cycle
            if (strap_load)
            begin
                start_r  <= st_s3_r;
                end_r    <= en_s3_r;
                loaded_r <= 1'b1;
            end
            else
            begin
                if (wr & sel_st)
                    start_r <= merge_win(start_r, wb_dat_i, wb_sel_i);
                if (wr & sel_end)
                    end_r <= merge_win(end_r, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ******************************************************************
    // Routing slots, one per channel and port
    // ******************************************************************
    logic               in_v    [2];
    dmr_pkg::dmr_req_t  in_q    [2];
    logic               in_rdy_r[2];
    logic               port_rdy[2][2];
    logic               slot_v_r[2][2];
    dmr_pkg::dmr_out_t  slot_r  [2][2];

    assign in_v[dmr_pkg::CH_AW]        = up_aw_valid;
    assign in_v[dmr_pkg::CH_AR]        = up_ar_valid;
    assign in_q[dmr_pkg::CH_AW]        = up_aw;
    assign in_q[dmr_pkg::CH_AR]        = up_ar;
    assign port_rdy[dmr_pkg::CH_AW][0] = m0_aw_ready;
    assign port_rdy[dmr_pkg::CH_AW][1] = m1_aw_ready;
    assign port_rdy[dmr_pkg::CH_AR][0] = m0_ar_ready;
    assign port_rdy[dmr_pkg::CH_AR][1] = m1_ar_ready;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        // Ready is registered, which costs one idle cycle per request
        wire       take = in_v[c] & in_rdy_r[c];
        wire       tgt  = route_port(in_q[c], filt_on, start_r, end_r);
        wire [1:0] v_nxt;
        wire [dmr_pkg::WIN_W-1:0] mb = in_q[c].addr[dmr_pkg::WIN_MSB:dmr_pkg::WIN_LSB];
        wire       in_win = (mb >= start_r) && (mb <= end_r);

        for (genvar p = 0; p < 2; p++)
        begin : g_port
            assign v_nxt[p] = (slot_v_r[c][p] & ~port_rdy[c][p]) | (take & (tgt == p));
            always_ff @(posedge mclk)
            begin
                if (!reset_n)
                begin
                    slot_v_r[c][p] <= 1'b0;
                    slot_r[c][p]   <= '0;
                end
                else
                begin
                    slot_v_r[c][p] <= v_nxt[p];
                    if (take & (tgt == p))
                        slot_r[c][p] <= shape(in_q[c], c == dmr_pkg::CH_AW);
                end
            end
        end

        always_ff @(posedge mclk)
        begin
            if (!reset_n)
                in_rdy_r[c] <= 1'b0;
            else
                in_rdy_r[c] <= ~v_nxt[0] & ~v_nxt[1];
        end

        sequence s_take;
            take;
        endsequence

        sequence s_in_port1;
            slot_v_r[c][1] && !slot_v_r[c][0];
        endsequence

        sequence s_in_port0;
            slot_v_r[c][0] && !slot_v_r[c][1];
        endsequence

        a_window_hit_port1: assert property (s_take and (filt_on && in_win) |=> s_in_port1)
            else $error("Window hit not routed to second port");
        a_window_miss_port0: assert property (s_take and (filt_on && !in_win) |=> s_in_port0)
            else $error("Window miss not routed to first port");
        a_lock_first_port: assert property (s_take and (!filt_on && in_q[c].lock != '0)
            |=> s_in_port0)
            else $error("Locked or exclusive access left the first port");
        a_source_id_user: assert property (s_take and (in_q[c].src == dmr_pkg::SRC_CSP)
            |=> slot_r[c][$past(tgt) ? 1 : 0].id[dmr_pkg::M_ID_W-1]
                && slot_r[c][$past(tgt) ? 1 : 0].user == dmr_pkg::SRC_CSP)
            else $error("Coherency port initiator not marked in ID and user");
        a_ready_after_take: assert property (s_take |=> !in_rdy_r[c] ##1 1'b1)
            else $error("Ready not withdrawn after a request was taken");
        a_slot_hold_stall: assert property (slot_v_r[c][0] && !port_rdy[c][0]
            |=> slot_v_r[c][0] && $stable(slot_r[c][0]))
            else $error("First port request changed while stalled");
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    assign up_aw_ready            = in_rdy_r[dmr_pkg::CH_AW];
    assign up_ar_ready            = in_rdy_r[dmr_pkg::CH_AR];
    assign m0_aw_valid            = slot_v_r[dmr_pkg::CH_AW][0];
    assign m0_aw                  = slot_r[dmr_pkg::CH_AW][0];
    assign m0_ar_valid            = slot_v_r[dmr_pkg::CH_AR][0];
    assign m0_ar                  = slot_r[dmr_pkg::CH_AR][0];
    assign m1_aw_valid            = slot_v_r[dmr_pkg::CH_AW][1];
    assign m1_aw                  = slot_r[dmr_pkg::CH_AW][1];
    assign m1_ar_valid            = slot_v_r[dmr_pkg::CH_AR][1];
    assign m1_ar                  = slot_r[dmr_pkg::CH_AR][1];
    assign first_port_write_lock  = slot_r[dmr_pkg::CH_AW][0].lock;
    assign second_port_write_lock = slot_r[dmr_pkg::CH_AW][1].lock;

    // ******************************************************************
    // Checks
    // ******************************************************************
    a_write_lock_low: assert property (!first_port_write_lock[dmr_pkg::LOCK_LOCKED_BIT]
        && !second_port_write_lock[dmr_pkg::LOCK_LOCKED_BIT])
        else $error("Locked write bit driven on a master port");
    a_strap_capture: assert property ($rose(loaded_r) |-> start_r == $past(st_s3_r)
        && end_r == $past(en_s3_r))
        else $error("Window bounds not taken from straps at reset release");
    a_strap_in_time: assert property ($rose(reset_n) |-> ##[1:8] loaded_r)
        else $error("Straps not captured within eight cycles of reset release");
    a_pin_enables: assert property (pin_stable && pin_sync_r[2] |=> filt_on [*2])
        else $error("Stable enable pin did not turn filtering on");
    a_ctrl_enables: assert property (wr && sel_ctrl && wb_sel_i[0]
        && wb_dat_i[dmr_pkg::CTRL_FILT_BIT] |=> filt_on)
        else $error("Control enable bit did not turn filtering on");
    a_wb_single_ack: assert property (wb_req |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o)
        else $error("Register bus answer not a single cycle");

endmodule : dmr_router

//--- rtl/dmr_pkg.sv
// Shared constants and carrier types for the dual master port router
package dmr_pkg;

    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int ADDR_W   = 32;
    localparam int WIN_MSB  = 31;
    localparam int WIN_LSB  = 20;
    localparam int WIN_W    = 12;
    localparam int CSP_ID_W = 4;
    localparam int M_ID_W   = CSP_ID_W + 1;
    localparam int LEN_W    = 4;
    localparam int LOCK_W   = 2;
    localparam int USER_W   = 2;
    localparam int WB_AW    = 8;
    localparam int WB_DW    = 32;

    // ******************************************************************
    // Lock field, initiator codes, port and channel indices
    // ******************************************************************
    localparam int LOCK_LOCKED_BIT = 1;
    localparam logic [USER_W-1:0] SRC_CPU0 = 2'h0;
    localparam logic [USER_W-1:0] SRC_CPU1 = 2'h1;
    localparam logic [USER_W-1:0] SRC_CSP  = 2'h2;
    localparam logic PORT0 = 1'b0;
    localparam logic PORT1 = 1'b1;
    localparam int   CH_AW = 0;
    localparam int   CH_AR = 1;

    // ******************************************************************
    // Register map and reset values
    // ******************************************************************
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_START  = 8'h04;
    localparam logic [WB_AW-1:0] REG_END    = 8'h08;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h0C;
    localparam int CTRL_FILT_BIT  = 0;
    localparam int STAT_FILT_BIT  = 0;
    localparam int STAT_PIN_BIT   = 1;
    localparam int STAT_LOAD_BIT  = 2;
    localparam logic [WIN_W-1:0] WIN_RST = 12'h000;

    // ******************************************************************
    // Carriers
    // ******************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [CSP_ID_W-1:0] id;
        logic [LEN_W-1:0]    len;
        logic [LOCK_W-1:0]   lock;
        logic [USER_W-1:0]   src;
    } dmr_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [M_ID_W-1:0]   id;
        logic [LEN_W-1:0]    len;
        logic [LOCK_W-1:0]   lock;
        logic [USER_W-1:0]   user;
        logic                par;
    } dmr_out_t;

endpackage : dmr_pkg

//--- test/dmr_port_sink.sv
// Far-side address channel model that accepts requests promptly or with stalls
`timescale 1ns/1ps
module dmr_port_sink (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Channel handshake
    input  wire logic valid,
    input  wire logic slow,
    output logic      ready
);
    logic [1:0] cnt_r;
    // Slow mode refuses three cycles in four, so held requests get exercised
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cnt_r <= 2'h0;
            ready <= 1'b0;
        end
        else
        begin
            // Stall pattern advances only while a request waits
            if (valid)
                cnt_r <= cnt_r + 2'h1;
            // Plain interconnect, no cache behind the port, so filtering may be on
            ready <= !slow || (cnt_r == 2'h3);
        end
    end
endmodule : dmr_port_sink

//--- test/tb.sv
// Self-checking bench of the dual master port router
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic              port;
        logic              ch;
        dmr_pkg::dmr_out_t o;
    } dmr_exp_t;

    logic              mclk, reset_n, cyc, stb, we, ack, err, pin, slow, ctrl_on, er;
    logic [7:0]        adr;
    logic [31:0]       wdat, rdat, rd, seed;
    logic [3:0]        sel;
    logic [11:0]       s_strap, e_strap, win_lo, win_hi;
    logic              aw_v, ar_v, aw_rdy, ar_rdy, m0_awv, m0_arv, m1_awv, m1_arv;
    logic              r0a, r0r, r1a, r1r;
    logic [1:0]        wl0, wl1;
    dmr_pkg::dmr_req_t aw, ar;
    dmr_pkg::dmr_out_t m0_aw, m0_ar, m1_aw, m1_ar;
    int                errors, checks_done;
    dmr_exp_t          q[$];

    dmr_router #(.PAR_EN(1'b1)) dut_u (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .filter_enable_pin(pin),
        .filter_window_start_strap(s_strap), .filter_window_end_strap(e_strap),
        .up_aw_valid(aw_v), .up_aw(aw), .up_aw_ready(aw_rdy), .up_ar_valid(ar_v), .up_ar(ar),
        .up_ar_ready(ar_rdy), .m0_aw_valid(m0_awv), .m0_aw(m0_aw), .m0_aw_ready(r0a),
        .m0_ar_valid(m0_arv), .m0_ar(m0_ar), .m0_ar_ready(r0r), .first_port_write_lock(wl0),
        .m1_aw_valid(m1_awv), .m1_aw(m1_aw), .m1_aw_ready(r1a), .m1_ar_valid(m1_arv),
        .m1_ar(m1_ar), .m1_ar_ready(r1r), .second_port_write_lock(wl1));
    dmr_port_sink s0a_u (.mclk(mclk), .reset_n(reset_n), .valid(m0_awv), .slow(slow), .ready(r0a));
    dmr_port_sink s0r_u (.mclk(mclk), .reset_n(reset_n), .valid(m0_arv), .slow(slow), .ready(r0r));
    dmr_port_sink s1a_u (.mclk(mclk), .reset_n(reset_n), .valid(m1_awv), .slow(slow), .ready(r1a));
    dmr_port_sink s1r_u (.mclk(mclk), .reset_n(reset_n), .valid(m1_arv), .slow(slow), .ready(r1r));

    // ******************************************************************
    // Checking
    // ******************************************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_req(input dmr_exp_t got);
        dmr_exp_t exp;
        checks_done++;
        exp = (q.size() > 0) ? q.pop_front() : '0;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_req

    // Outputs are sampled as they stood before the edge, the same view the port has
    always @(posedge mclk)
    begin
        if (reset_n)
        begin
            if (m0_awv && r0a) cmp_req({1'b0, 1'b0, m0_aw});
            if (m0_arv && r0r) cmp_req({1'b0, 1'b1, m0_ar});
            if (m1_awv && r1a) cmp_req({1'b1, 1'b0, m1_aw});
            if (m1_arv && r1r) cmp_req({1'b1, 1'b1, m1_ar});
            if (m0_awv) cmp_reg({30'h0, wl0}, {31'h0, m0_aw.lock[0]});
            if (m1_awv) cmp_reg({30'h0, wl1}, {31'h0, m1_aw.lock[0]});
        end
    end

    // ******************************************************************
    // Drivers
    // ******************************************************************
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
        int n;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        for (n = 0; n < 20 && !(ack || err); n++)
            @(posedge mclk);
        rd = rdat;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : wb_xfer

    task automatic send(input logic c, input logic [31:0] a, input logic [1:0] l,
                        input logic [1:0] s);
        dmr_pkg::dmr_req_t r;
        dmr_exp_t          e;
        int                n;
        r = {a, 4'($random(seed)), 4'($random(seed)), l, s};
        // Routing model: window hit when filtering, else locked stays on the first port
        if (pin || ctrl_on)
            e.port = (a[31:20] >= win_lo) && (a[31:20] <= win_hi);
        else
            e.port = (l == 2'h0) && (s == dmr_pkg::SRC_CPU1);
        e.ch = c;
        e.o.addr = a;
        e.o.id = {s == dmr_pkg::SRC_CSP, r.id};
        e.o.len = r.len;
        e.o.lock = c ? l : {1'b0, l[0]};
        e.o.user = s;
        e.o.par = ^{e.o.addr, e.o.id, e.o.len, e.o.lock, e.o.user};
        q.push_back(e);
        @(posedge mclk);
        aw_v <= !c;
        ar_v <= c;
        aw   <= r;
        ar   <= r;
        // Ready is judged at each edge after valid went up, never in the launch step
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (n < 20 && !(c ? ar_rdy : aw_rdy));
        aw_v <= 1'b0;
        ar_v <= 1'b0;
        for (n = 0; n < 40 && q.size() > 0; n++)
            @(posedge mclk);
        if (n == 40)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : send

    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        seed = 32'h50C3;
        {reset_n, cyc, stb, we, pin, slow, ctrl_on, aw_v, ar_v} = '0;
        {adr, wdat, sel, aw, ar, errors, checks_done} = '0;
        s_strap = 12'h100;
        e_strap = 12'h103;
        win_lo = 12'h100;
        win_hi = 12'h103;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        wb_xfer(1'b0, dmr_pkg::REG_START, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0100);
        wb_xfer(1'b0, dmr_pkg::REG_END, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0103);
        wb_xfer(1'b0, dmr_pkg::REG_STATUS, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0004);
        wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        cmp_reg({31'h0, er}, 32'h1);
        $display("test straps_and_map done");
        for (int c = 0; c < 2; c++)
            for (int s = 0; s < 3; s++)
                for (int l = 0; l < 4; l++)
                    send(c[0], 32'h1018_0040, l[1:0], s[1:0]);
        $display("test unfiltered done");
        pin <= 1'b1;
        slow <= 1'b1;
        repeat (6) @(posedge mclk);
        wb_xfer(1'b0, dmr_pkg::REG_STATUS, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0007);
        for (int s = 0; s < 2; s++)
        begin
            send(s[0], 32'h0FFF_FFFF, 2'h1, s[1:0]);
            send(s[0], 32'h1000_0000, 2'h1, s[1:0]);
            send(s[0], 32'h103F_FFFF, 2'h2, s[1:0]);
            send(s[0], 32'h1040_0000, 2'h0, 2'h1);
        end
        $display("test pin_filter done");
        pin <= 1'b0;
        slow <= 1'b0;
        wb_xfer(1'b1, dmr_pkg::REG_CTRL, 32'h0000_0001, 4'hF);
        ctrl_on = 1'b1;
        wb_xfer(1'b1, dmr_pkg::REG_START, 32'hFFFF_F7F0, 4'hF);
        wb_xfer(1'b1, dmr_pkg::REG_END, 32'h0000_0FFF, 4'h2);
        wb_xfer(1'b0, dmr_pkg::REG_END, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0F03);
        wb_xfer(1'b1, dmr_pkg::REG_END, 32'h0000_00F0, 4'h1);
        wb_xfer(1'b1, dmr_pkg::REG_END, 32'h0000_0700, 4'h2);
        win_lo = 12'h7F0;
        win_hi = 12'h7F0;
        repeat (6) @(posedge mclk);
        wb_xfer(1'b0, dmr_pkg::REG_STATUS, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_0005);
        send(1'b1, 32'h7EFF_FFFF, 2'h0, 2'h1);
        send(1'b0, 32'h7F00_0000, 2'h1, 2'h0);
        send(1'b1, 32'h7FFF_FFFF, 2'h2, 2'h2);
        send(1'b0, 32'h7F10_0000, 2'h0, 2'h1);
        $display("test register_filter done");
        for (int k = 0; k < 40; k++)
        begin
            if (k == 20)
            begin
                wb_xfer(1'b1, dmr_pkg::REG_CTRL, 32'h0, 4'hF);
                ctrl_on = 1'b0;
            end
            slow <= 1'($random(seed));
            send(1'($random(seed)), {k[0] ? 12'h7F0 : 12'($random(seed)), 20'($random(seed))},
                 2'($random(seed)), 2'($unsigned($random(seed))) % 2'h3);
        end
        $display("test random_traffic done");
        tally_and_finish();
    end
endmodule : tb
